/* rtl/haem_monitor.sv */
// Notes on behaviour
// - code 0x53 counts directory lookups
// - lookup bit0: snoops needed, directory dirty
// - lookup bit1: no snoops, directory clean
// - code 0x54 counts directory updates
// - update bit0: home pipe writes, no writebacks
// - update bit1: request tracker pipe writes
// - directory events meaningful only with directory
// - code 0x5f bit0: remote exclusive read hits
// - hit bit2: shared ownership request hits
// - hit bits3,4: writeback to exclusive, invalid/shared
// - code 0x5e bit0 reads, bit1 writebacks
// - code 0x60 bits5,6: shared/unshared ownership misses
// - miss bit7: remote read or invalidate
// - code 0x61 bit0: local forward converted
// - update bit1: remote forward updated
// - update bits2-4: shared, ownership read, deallocate
// - code 0x59 bit0 normal, bit1 isochronous reads
// - reads issued plus bypass equal column reads
// - code 0x5b bits0-3 write kinds
// - ownership reads cause directory update writes
module haem_monitor
   import haem_pkg::*;
#(
   parameter int CNT_W = 48,
   parameter bit HAS_DIRECTORY = 1'b1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire haem_occ_t occ,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic count_inc
);
   // ************************************************************
   // control and event selection
   // ************************************************************
   logic [31:0] ctl_reg;
   logic [CNT_W-1:0] cnt_reg;
   wire [7:0] evt_code = ctl_reg[HAEM_CODE_MSB:HAEM_CODE_LSB];
   wire [7:0] umask = ctl_reg[HAEM_UMASK_MSB:HAEM_UMASK_LSB];
   wire count_en = ctl_reg[HAEM_EN_BIT];
   wire dir_ok = HAS_DIRECTORY;

   wire [7:0] sel_occ =
      (evt_code == HAEM_EVT_DIR_LOOKUP) ? (dir_ok ? occ.dir_lookup : 8'h00) :
      (evt_code == HAEM_EVT_DIR_UPDATE) ? (dir_ok ? occ.dir_update : 8'h00) :
      (evt_code == HAEM_EVT_BYPASS) ? occ.bypass :
      (evt_code == HAEM_EVT_MEM_READ) ? occ.mem_read :
      (evt_code == HAEM_EVT_MEM_WRITE) ? occ.mem_write :
      (evt_code == HAEM_EVT_OC_LOOKUP) ? occ.oc_lookup :
      (evt_code == HAEM_EVT_OC_HIT) ? occ.oc_hit :
      (evt_code == HAEM_EVT_OC_MISS) ? occ.oc_miss :
      (evt_code == HAEM_EVT_OC_UPDATE) ? occ.oc_update :
      8'h00;
   wire inc_now = count_en && |(sel_occ & umask);

   // ************************************************************
   // bus slave
   // ************************************************************
   haem_wr_state_t wr_state_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   wire wr_go = clk_en && wr_state_reg == HAEM_WR_IDLE && s_axi_awvalid && s_axi_wvalid;
   wire wr_ctl = wr_go && s_axi_awaddr == HAEM_ADDR_CTL;
   wire wr_cnt = wr_go && s_axi_awaddr == HAEM_ADDR_CNT;
   wire wr_ok = s_axi_awaddr == HAEM_ADDR_CTL || s_axi_awaddr == HAEM_ADDR_CNT;
   wire rd_go = clk_en && !rvalid_reg && s_axi_arvalid;
   logic [31:0] wmask;
   logic [31:0] rd_val;
   logic rd_ok;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_strb
         assign wmask[gi*8 +: 8] = {8{s_axi_wstrb[gi]}};
      end
   endgenerate

   always_comb begin
      rd_ok = 1'b1;
      if (s_axi_araddr == HAEM_ADDR_CTL) begin
         rd_val = ctl_reg;
      end else if (s_axi_araddr == HAEM_ADDR_CNT) begin
         rd_val = cnt_reg[31:0];
      end else if (s_axi_araddr == HAEM_ADDR_STAT) begin
         rd_val = 32'(cnt_reg[CNT_W-1:32]);
      end else begin
         rd_val = 32'h0000_0000;
         rd_ok = 1'b0;
      end
   end

   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_bvalid = wr_state_reg == HAEM_WR_RESP;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = rd_go;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_reg <= HAEM_WR_IDLE;
         bresp_reg <= HAEM_RESP_OKAY;
         ctl_reg <= HAEM_CTL_RESET;
      end else if (clk_en) begin
         case (wr_state_reg)
            HAEM_WR_IDLE: begin
               if (wr_go) begin
                  wr_state_reg <= HAEM_WR_RESP;
                  bresp_reg <= wr_ok ? HAEM_RESP_OKAY : HAEM_RESP_SLVERR;
               end
            end
            default: begin
               if (s_axi_bready) begin
                  wr_state_reg <= HAEM_WR_IDLE;
               end
            end
         endcase
         if (wr_ctl) begin
            ctl_reg <= (ctl_reg & ~wmask) | (s_axi_wdata & wmask);
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= HAEM_RESP_OKAY;
      end else if (clk_en) begin
         if (rd_go) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_val;
            rresp_reg <= rd_ok ? HAEM_RESP_OKAY : HAEM_RESP_SLVERR;
         end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   // ************************************************************
   // counter
   // ************************************************************
   logic inc_reg;
   wire [CNT_W-1:0] cnt_wr = {cnt_reg[CNT_W-1:32],
      (cnt_reg[31:0] & ~wmask) | (s_axi_wdata & wmask)};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_reg <= CNT_W'(HAEM_CNT_RESET);
         inc_reg <= 1'b0;
      end else if (clk_en) begin
         inc_reg <= inc_now;
         if (wr_cnt) begin
            cnt_reg <= cnt_wr;
         end else if (inc_now) begin
            cnt_reg <= cnt_reg + CNT_W'(1);
         end
      end
   end
   assign count_inc = inc_reg;

   // ************************************************************
   // checks
   // ************************************************************
   chk_inc_match: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && count_en && |(sel_occ & umask) |=> count_inc)
      else $error("match did not raise increment");
   chk_inc_cause: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && !(count_en && |(sel_occ & umask)) |=> !count_inc)
      else $error("increment without match");
   chk_dir_lookup: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && count_en && evt_code == HAEM_EVT_DIR_LOOKUP && dir_ok
      && |(occ.dir_lookup & umask) |=> count_inc)
      else $error("directory lookup missed");
   chk_dir_masked: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && evt_code == HAEM_EVT_DIR_LOOKUP && umask == 8'h01
      && !occ.dir_lookup[0] |=> !count_inc)
      else $error("lookup counted without snoop");
   chk_no_dir: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && !dir_ok && (evt_code == HAEM_EVT_DIR_UPDATE
      || evt_code == HAEM_EVT_DIR_LOOKUP) |=> !count_inc)
      else $error("directory count without directory");
   chk_wr_sel: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && count_en && evt_code == HAEM_EVT_MEM_WRITE
      && |(occ.mem_write & umask) |=> count_inc)
      else $error("memory write missed");
   chk_oc_miss: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && count_en && evt_code == HAEM_EVT_OC_MISS
      && umask[7] && occ.oc_miss[7] |=> count_inc)
      else $error("owner cache miss missed");
   chk_cnt_step: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && inc_now && !wr_cnt |=> cnt_reg == $past(cnt_reg) + CNT_W'(1))
      else $error("counter did not step");
   chk_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   cov_dir: cover property (@(posedge aclk) count_inc && evt_code == HAEM_EVT_DIR_UPDATE);
   cov_oc: cover property (@(posedge aclk) count_inc && evt_code == HAEM_EVT_OC_HIT);
   cov_rd: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
   cov_freeze: cover property (@(posedge aclk) !clk_en ##1 clk_en);
   cov_slverr: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bresp == HAEM_RESP_SLVERR);

   // ************************************************************
   // per subevent checks
   // ************************************************************
   chk_lookup_snoop: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && count_en && evt_code == HAEM_EVT_DIR_LOOKUP && dir_ok
      && umask[0] && occ.dir_lookup[0] |=> count_inc)
      else $error("snoop needed lookup missed");
   chk_lookup_clean: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && count_en && evt_code == HAEM_EVT_DIR_LOOKUP && dir_ok
      && umask[1] && occ.dir_lookup[1] |=> count_inc)
      else $error("snoop not needed lookup missed");
   chk_clean_masked: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && evt_code == HAEM_EVT_DIR_LOOKUP && umask == 8'h02
      && !occ.dir_lookup[1] |=> !count_inc)
      else $error("clean lookup counted without occurrence");
   chk_update_any: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && count_en && evt_code == HAEM_EVT_DIR_UPDATE && dir_ok
      && |(occ.dir_update & umask) |=> count_inc)
      else $error("directory update missed");
   chk_update_home: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && count_en && evt_code == HAEM_EVT_DIR_UPDATE && dir_ok
      && umask[0] && occ.dir_update[0] |=> count_inc)
      else $error("home pipe update missed");
   chk_update_tracker: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && count_en && evt_code == HAEM_EVT_DIR_UPDATE && dir_ok
      && umask[1] && occ.dir_update[1] |=> count_inc)
      else $error("tracker pipe update missed");
   chk_hit_excl: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && count_en && evt_code == HAEM_EVT_OC_HIT
      && umask[0] && occ.oc_hit[0] |=> count_inc)
      else $error("exclusive read hit missed");
   chk_hit_shared: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && count_en && evt_code == HAEM_EVT_OC_HIT
      && umask[2] && occ.oc_hit[2] |=> count_inc)
      else $error("shared ownership hit missed");
   chk_hit_wb_excl: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && count_en && evt_code == HAEM_EVT_OC_HIT
      && umask[3] && occ.oc_hit[3] |=> count_inc)
      else $error("writeback to exclusive missed");
   chk_hit_wb_inv: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && count_en && evt_code == HAEM_EVT_OC_HIT
      && umask[4] && occ.oc_hit[4] |=> count_inc)
      else $error("writeback to invalid or shared missed");
   chk_oclook_read: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && count_en && evt_code == HAEM_EVT_OC_LOOKUP
      && umask[0] && occ.oc_lookup[0] |=> count_inc)
      else $error("owner cache read lookup missed");
   chk_oclook_wb: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && count_en && evt_code == HAEM_EVT_OC_LOOKUP
      && umask[1] && occ.oc_lookup[1] |=> count_inc)
      else $error("owner cache writeback lookup missed");
   chk_oclook_masked: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && evt_code == HAEM_EVT_OC_LOOKUP && umask == 8'h01
      && !occ.oc_lookup[0] |=> !count_inc)
      else $error("lookup counted without read");
   chk_miss_shared: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && count_en && evt_code == HAEM_EVT_OC_MISS
      && umask[5] && occ.oc_miss[5] |=> count_inc)
      else $error("shared ownership miss missed");
   chk_miss_unshared: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && count_en && evt_code == HAEM_EVT_OC_MISS
      && umask[6] && occ.oc_miss[6] |=> count_inc)
      else $error("unshared ownership miss missed");
   chk_upd_local: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && count_en && evt_code == HAEM_EVT_OC_UPDATE
      && umask[0] && occ.oc_update[0] |=> count_inc)
      else $error("local forward conversion missed");
   chk_upd_remote: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && count_en && evt_code == HAEM_EVT_OC_UPDATE
      && umask[1] && occ.oc_update[1] |=> count_inc)
      else $error("remote forward update missed");
   chk_upd_shared: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && count_en && evt_code == HAEM_EVT_OC_UPDATE
      && umask[2] && occ.oc_update[2] |=> count_inc)
      else $error("shared update missed");
   chk_upd_own: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && count_en && evt_code == HAEM_EVT_OC_UPDATE
      && umask[3] && occ.oc_update[3] |=> count_inc)
      else $error("ownership read update missed");
   chk_upd_dealloc: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && count_en && evt_code == HAEM_EVT_OC_UPDATE
      && umask[4] && occ.oc_update[4] |=> count_inc)
      else $error("deallocation missed");
   chk_read_normal: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && count_en && evt_code == HAEM_EVT_MEM_READ
      && umask[0] && occ.mem_read[0] |=> count_inc)
      else $error("normal read missed");
   chk_read_isochronous_priority: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && count_en && evt_code == HAEM_EVT_MEM_READ
      && umask[1] && occ.mem_read[1] |=> count_inc)
      else $error("isochronous read missed");
   chk_read_masked: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && evt_code == HAEM_EVT_MEM_READ && umask == 8'h02
      && !occ.mem_read[1] |=> !count_inc)
      else $error("read counted without isochronous read");
   chk_bypass_taken: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && count_en && evt_code == HAEM_EVT_BYPASS
      && umask[0] && occ.bypass[0] |=> count_inc)
      else $error("taken bypass missed");
   chk_write_full: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && count_en && evt_code == HAEM_EVT_MEM_WRITE
      && umask[0] && occ.mem_write[0] |=> count_inc)
      else $error("full write missed");
   chk_write_part: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && count_en && evt_code == HAEM_EVT_MEM_WRITE
      && umask[1] && occ.mem_write[1] |=> count_inc)
      else $error("partial write missed");
   chk_write_isofull: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && count_en && evt_code == HAEM_EVT_MEM_WRITE
      && umask[2] && occ.mem_write[2] |=> count_inc)
      else $error("isochronous full write missed");
   chk_write_isopart: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && count_en && evt_code == HAEM_EVT_MEM_WRITE
      && umask[3] && occ.mem_write[3] |=> count_inc)
      else $error("isochronous partial write missed");

   // ************************************************************
   // bus and freeze checks
   // ************************************************************
   chk_freeze_state: assert property (@(posedge aclk) disable iff (!aresetn)
      !clk_en |=> $stable(cnt_reg) && $stable(ctl_reg) && $stable(count_inc))
      else $error("state moved while frozen");
   chk_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read response dropped");
   chk_aw_pair: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_awready |-> s_axi_awvalid && s_axi_wvalid && clk_en)
      else $error("address taken without data");
   chk_ar_busy: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arready |-> !s_axi_rvalid && clk_en)
      else $error("read taken while response pending");
   chk_wr_slverr: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_go && !wr_ok |=> s_axi_bvalid && s_axi_bresp == HAEM_RESP_SLVERR)
      else $error("unmapped write not refused");
   chk_ctl_write: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_ctl && s_axi_wstrb == 4'hf |=> ctl_reg == $past(s_axi_wdata))
      else $error("control write lost");
endmodule

/* rtl/haem_pkg.sv */
package haem_pkg;
   // ************************************************************
   // event codes
   // ************************************************************
   localparam logic [7:0] HAEM_EVT_DIR_LOOKUP = 8'h53;
   localparam logic [7:0] HAEM_EVT_DIR_UPDATE = 8'h54;
   localparam logic [7:0] HAEM_EVT_BYPASS = 8'h57;
   localparam logic [7:0] HAEM_EVT_MEM_READ = 8'h59;
   localparam logic [7:0] HAEM_EVT_MEM_WRITE = 8'h5b;
   localparam logic [7:0] HAEM_EVT_OC_LOOKUP = 8'h5e;
   localparam logic [7:0] HAEM_EVT_OC_HIT = 8'h5f;
   localparam logic [7:0] HAEM_EVT_OC_MISS = 8'h60;
   localparam logic [7:0] HAEM_EVT_OC_UPDATE = 8'h61;

   // ************************************************************
   // control word layout
   // ************************************************************
   localparam int HAEM_CODE_LSB = 0;
   localparam int HAEM_CODE_MSB = 7;
   localparam int HAEM_UMASK_LSB = 8;
   localparam int HAEM_UMASK_MSB = 15;
   localparam int HAEM_EN_BIT = 22;

   // ************************************************************
   // register map (byte addresses)
   // ************************************************************
   localparam logic [7:0] HAEM_ADDR_CTL = 8'h00;
   localparam logic [7:0] HAEM_ADDR_CNT = 8'h04;
   localparam logic [7:0] HAEM_ADDR_STAT = 8'h08;
   localparam logic [31:0] HAEM_CTL_RESET = 32'h0000_0000;
   localparam logic [31:0] HAEM_CNT_RESET = 32'h0000_0000;
   localparam logic [1:0] HAEM_RESP_OKAY = 2'b00;
   localparam logic [1:0] HAEM_RESP_SLVERR = 2'b10;

   // ************************************************************
   // occurrence strobes from the home agent, one bit per subevent
   // ************************************************************
   typedef struct packed {
      logic [7:0] dir_lookup;
      logic [7:0] dir_update;
      logic [7:0] bypass;
      logic [7:0] mem_read;
      logic [7:0] mem_write;
      logic [7:0] oc_lookup;
      logic [7:0] oc_hit;
      logic [7:0] oc_miss;
      logic [7:0] oc_update;
   } haem_occ_t;

   typedef enum logic [1:0] {
      HAEM_WR_IDLE = 2'b00,
      HAEM_WR_RESP = 2'b01
   } haem_wr_state_t;
endpackage

/* testbench/haem_occ_model.sv */
module haem_occ_model
   import haem_pkg::*;
(
   input wire logic aclk,
   input wire logic fire,
   input wire logic [3:0] sel,
   input wire logic [7:0] bits,
   output haem_occ_t occ
);
   // ************************************************************
   // pipeline strobes, one cycle each, field 0 is the top byte
   // ************************************************************
   logic [71:0] occ_next;
   always_comb begin
      occ_next = '0;
      if (fire) begin
         occ_next[(8 - int'(sel)) * 8 +: 8] = bits;
      end
   end
   always_ff @(posedge aclk) begin
      occ <= occ_next;
   end
endmodule

/* testbench/home_agent_event_monitor_tb.sv */
module home_agent_event_monitor_tb import haem_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 0, aresetn = 0, fire = 0, cur_en = 0, run_en = 1;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, count_inc;
   logic [1:0] bresp, rresp;
   logic [3:0] sel = '0;
   logic [7:0] bits = '0, awaddr = '0, araddr = '0, cur_um = '0;
   logic [31:0] wdata = '0, rdata, seed = 32'h0000_0061;
   logic [47:0] exp_cnt = '0;
   logic [33:0] exp_q[$];
   bit inc_q[$];
   int bad_count = 0, cmp_count = 0, cur_s = 0;
   logic [7:0] codes[9] = '{HAEM_EVT_DIR_LOOKUP, HAEM_EVT_DIR_UPDATE, HAEM_EVT_BYPASS,
      HAEM_EVT_MEM_READ, HAEM_EVT_MEM_WRITE, HAEM_EVT_OC_LOOKUP, HAEM_EVT_OC_HIT,
      HAEM_EVT_OC_MISS, HAEM_EVT_OC_UPDATE};
   haem_occ_t occ;
   always #2 aclk = ~aclk;
   haem_occ_model occ_u (.aclk(aclk), .fire(fire), .sel(sel), .bits(bits), .occ(occ));
   haem_monitor dut_u (.aclk(aclk), .aresetn(aresetn), .clk_en(run_en), .occ(occ),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .count_inc(count_inc));
   // ************************************************************
   // stimulus helpers
   // ************************************************************
   function logic [7:0] rnd8();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge aclk);
      fire <= 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      exp_q.push_back({r, 32'h0000_0000});
      @(posedge aclk);
      while (awready !== 1'b1) @(posedge aclk);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      @(posedge aclk);
      while (bvalid !== 1'b1) @(posedge aclk);
      bready <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [33:0] e);
      @(posedge aclk);
      fire <= 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      exp_q.push_back(e);
      @(posedge aclk);
      while (arready !== 1'b1) @(posedge aclk);
      arvalid <= 1'b0;
      @(posedge aclk);
      while (rvalid !== 1'b1) @(posedge aclk);
      rready <= 1'b0;
   endtask
   task set_ctl(input int s, input int b, input logic en);
      cur_s = s;
      cur_um = 8'(1 << b);
      cur_en = en;
      wr(HAEM_ADDR_CTL, {9'h000, en, 6'h00, cur_um, codes[s]}, HAEM_RESP_OKAY);
   endtask
   task fire_one(input int s, input logic [7:0] b);
      @(posedge aclk);
      sel <= 4'(s);
      bits <= b;
      fire <= 1'b1;
      if (s == cur_s && cur_en && (b & cur_um) != 8'h00) begin
         inc_q.push_back(1'b1);
         exp_cnt = exp_cnt + 48'h1;
      end
   endtask
   // ************************************************************
   // result watcher
   // ************************************************************
   function void chk(input logic [33:0] got);
      logic [33:0] e;
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
      cmp_count++;
      if (e !== got) begin
         bad_count++;
         $display("ERROR %0t bus result %h expected %h", $time, got, e);
      end
   endfunction
   always @(posedge aclk) begin
      if (bvalid === 1'b1 && bready === 1'b1) chk({bresp, 32'h0000_0000});
      if (rvalid === 1'b1 && rready === 1'b1) chk({rresp, rdata});
      if (count_inc === 1'b1) begin
         cmp_count++;
         if (inc_q.size() == 0) begin
            bad_count++;
            $display("ERROR %0t unexpected increment", $time);
         end else begin
            void'(inc_q.pop_front());
         end
      end
   end
   task final_report();
      if (inc_q.size() != 0 || exp_q.size() != 0) begin
         bad_count++;
         $display("ERROR %0t results missing", $time);
      end
      $display("compares %0d errors %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // ************************************************************
   // main sequence and watchdog
   // ************************************************************
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(HAEM_ADDR_CTL, {HAEM_RESP_OKAY, HAEM_CTL_RESET});
      rd(8'h0c, {HAEM_RESP_SLVERR, 32'h0000_0000});
      wr(8'h0c, 32'hffff_ffff, HAEM_RESP_SLVERR);
      exp_cnt = 48'h0000_ffff_fff0;
      wr(HAEM_ADDR_CNT, exp_cnt[31:0], HAEM_RESP_OKAY);
      set_ctl(0, 0, 1'b0);
      fire_one(0, 8'hff);
      for (int s = 0; s < 9; s++) begin
         for (int b = 0; b < 8; b++) begin
            set_ctl(s, b, 1'b1);
            fire_one(s, rnd8());
            fire_one((s + 1) % 9, 8'hff);
         end
         rd(HAEM_ADDR_CNT, {HAEM_RESP_OKAY, exp_cnt[31:0]});
      end
      rd(HAEM_ADDR_STAT, {HAEM_RESP_OKAY, 16'h0000, exp_cnt[47:32]});
      rd(HAEM_ADDR_CTL, {HAEM_RESP_OKAY, 32'h0040_8061});
      @(posedge aclk);
      run_en <= 1'b0;
      sel <= 4'd8;
      bits <= 8'h80;
      fire <= 1'b1;
      @(posedge aclk);
      fire <= 1'b0;
      repeat (3) @(posedge aclk);
      run_en <= 1'b1;
      rd(HAEM_ADDR_CNT, {HAEM_RESP_OKAY, exp_cnt[31:0]});
      repeat (4) @(posedge aclk);
      final_report();
   end
   initial begin
      #100000;
      bad_count++;
      $display("ERROR %0t watchdog expired", $time);
      final_report();
   end
endmodule
